/* logic/jtdr_pkg.sv */
`include "jtdr_regs.svh"

package jtdr_pkg;

  // TAP controller states, Gray steps along the scan paths
  typedef enum logic [3:0] {
    JTDR_TLR = 4'h0,
    JTDR_RTI = 4'h1,
    JTDR_SELDR = 4'h3,
    JTDR_CAPDR = 4'h2,
    JTDR_SHDR = 4'h6,
    JTDR_EX1DR = 4'h7,
    JTDR_PAUDR = 4'h5,
    JTDR_EX2DR = 4'h4,
    JTDR_UPDDR = 4'hc,
    JTDR_SELIR = 4'hd,
    JTDR_CAPIR = 4'hf,
    JTDR_SHIR = 4'he,
    JTDR_EX1IR = 4'ha,
    JTDR_PAUIR = 4'hb,
    JTDR_EX2IR = 4'h9,
    JTDR_UPDIR = 4'h8
  } jtdr_tap_e;

  typedef logic [`JTDR_IR_W-1:0] jtdr_ir_t;
  typedef logic [`JTDR_BSR_LEN-1:0] jtdr_cells_t;

  // Pin takeover modes decoded from the current instruction
  typedef struct packed {
    logic extest;
    logic clamp;
    logic highz;
  } jtdr_mode_s;

endpackage : jtdr_pkg

/* logic/jtdr_regs.svh */
`ifndef JTDR_REGS_SVH
`define JTDR_REGS_SVH

// Instruction register geometry and opcodes
`define JTDR_IR_W 3
`define JTDR_OP_SAMPLE 3'h2
`define JTDR_OP_BYPASS 3'h7
`define JTDR_OP_EXTEST 3'h0
`define JTDR_OP_CLAMP 3'h3
`define JTDR_OP_HIGHZ 3'h4
`define JTDR_OP_IDCODE 3'h1
// Fixed pattern loaded by capture-IR
`define JTDR_IR_CAPTURE 3'h1

// Identification word layout
`define JTDR_ID_W 32
`define JTDR_ID_REV_HI 31
`define JTDR_ID_REV_LO 28
`define JTDR_ID_DEV_HI 27
`define JTDR_ID_DEV_LO 12
`define JTDR_ID_MFR_HI 11
`define JTDR_ID_MFR_LO 1
`define JTDR_ID_FIXED_BIT 0

// Boundary chain length, one cell per digital I/O pin
`define JTDR_BSR_LEN 8

// Bypass capture value
`define JTDR_BYPASS_CAPTURE 1'h0

`endif

/* logic/jtdr_top.sv */
`timescale 1ns/1ps
// Function
// R1 - ID word: revision top, 16-bit device, 11-bit maker, bit zero one.
// R2 - Bypass and boundary registers present, plus an identification register.
// R3 - Boundary register: shift path and latched parallel stage over all cells.
// R4 - Bypass is one stage, used for bypass, clamp and high-impedance.
// R5 - Identification register has 32-bit shift and 32-bit parallel stages.
// R6 - ID register selected under the ID instruction and in test-logic-reset.
// R7 - Opcodes: sample 010, bypass 111, extest 000, clamp 011, highz 100, id 001.
// R8 - ID code loaded at capture-DR, then shifted out during shift-DR.
// R9 - Three-bit instruction register, parallel stage updated on falling edge.
// R10 - Boundary length is a build parameter with fixed cell order.
`include "jtdr_regs.svh"

module jtdr_top
  import jtdr_pkg::*;
#(
  parameter logic [3:0] ID_REVISION = 4'h1,      // Arbitrary value
  parameter logic [15:0] ID_DEVICE = 16'h0a5c,   // Arbitrary value
  parameter logic [10:0] ID_MAKER = 11'h123      // Arbitrary value
)
(
  input wire logic clk,
  input wire logic srst,
  input wire logic scan_clock,
  input wire logic scan_reset_n,
  input wire logic scan_mode_select,
  input wire logic scan_serial_in,
  output logic scan_serial_out,
  output logic scan_serial_oe,
  input wire jtdr_cells_t pin_in,
  input wire jtdr_cells_t core_out,
  input wire jtdr_cells_t core_oe,
  output jtdr_cells_t pin_out,
  output jtdr_cells_t pin_oe
);

  // Identification word assembled from its fields
  localparam logic [`JTDR_ID_W-1:0] ID_WORD = {ID_REVISION, ID_DEVICE, ID_MAKER, 1'b1}; // see R1

  jtdr_tap_e tap_reg;
  jtdr_tap_e tap_next;
  jtdr_ir_t ir_sh_reg;
  jtdr_ir_t ir_reg;
  logic byp_reg;
  logic [`JTDR_ID_W-1:0] id_sh_reg;
  logic [`JTDR_ID_W-1:0] id_par_reg;
  jtdr_cells_t bsr_sh_reg;
  jtdr_cells_t bsr_par_reg;
  jtdr_cells_t pin_s1_reg;
  jtdr_cells_t pin_s2_reg;
  logic upd_tgl_reg;
  jtdr_mode_s mode_tck;
  jtdr_mode_s mode_tck_reg;
  logic sel_bsr;
  logic sel_id;
  logic sel_out;

  // TAP next state on the mode select line
  always_comb
  begin
    unique case (tap_reg)
      JTDR_TLR: tap_next = scan_mode_select ? JTDR_TLR : JTDR_RTI;
      JTDR_RTI: tap_next = scan_mode_select ? JTDR_SELDR : JTDR_RTI;
      JTDR_SELDR: tap_next = scan_mode_select ? JTDR_SELIR : JTDR_CAPDR;
      JTDR_CAPDR: tap_next = scan_mode_select ? JTDR_EX1DR : JTDR_SHDR;
      JTDR_SHDR: tap_next = scan_mode_select ? JTDR_EX1DR : JTDR_SHDR;
      JTDR_EX1DR: tap_next = scan_mode_select ? JTDR_UPDDR : JTDR_PAUDR;
      JTDR_PAUDR: tap_next = scan_mode_select ? JTDR_EX2DR : JTDR_PAUDR;
      JTDR_EX2DR: tap_next = scan_mode_select ? JTDR_UPDDR : JTDR_SHDR;
      JTDR_UPDDR: tap_next = scan_mode_select ? JTDR_SELDR : JTDR_RTI;
      JTDR_SELIR: tap_next = scan_mode_select ? JTDR_TLR : JTDR_CAPIR;
      JTDR_CAPIR: tap_next = scan_mode_select ? JTDR_EX1IR : JTDR_SHIR;
      JTDR_SHIR: tap_next = scan_mode_select ? JTDR_EX1IR : JTDR_SHIR;
      JTDR_EX1IR: tap_next = scan_mode_select ? JTDR_UPDIR : JTDR_PAUIR;
      JTDR_PAUIR: tap_next = scan_mode_select ? JTDR_EX2IR : JTDR_PAUIR;
      JTDR_EX2IR: tap_next = scan_mode_select ? JTDR_UPDIR : JTDR_SHIR;
      JTDR_UPDIR: tap_next = scan_mode_select ? JTDR_SELDR : JTDR_RTI;
    endcase
  end

  // TAP state, async test reset
  always_ff @(posedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
      tap_reg <= JTDR_TLR;
    else
      tap_reg <= tap_next;
  end

  // Register selection from the current instruction, ID also in test-logic-reset
  always_comb
  begin
    sel_bsr = (ir_reg == `JTDR_OP_EXTEST) || (ir_reg == `JTDR_OP_SAMPLE); // see R2, R7
    sel_id = (ir_reg == `JTDR_OP_IDCODE) || (tap_reg == JTDR_TLR); // see R6
    mode_tck.extest = (ir_reg == `JTDR_OP_EXTEST);
    mode_tck.clamp = (ir_reg == `JTDR_OP_CLAMP);
    mode_tck.highz = (ir_reg == `JTDR_OP_HIGHZ);
  end

  // Modes registered before crossing, so decode glitches stay on this side
  always_ff @(negedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
      mode_tck_reg <= '0;
    else
      mode_tck_reg <= mode_tck;
  end

  // Instruction shift stage: fixed capture, shift toward the output
  always_ff @(posedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
      ir_sh_reg <= `JTDR_IR_CAPTURE;
    else if (tap_reg == JTDR_CAPIR)
      ir_sh_reg <= `JTDR_IR_CAPTURE;
    else if (tap_reg == JTDR_SHIR)
      ir_sh_reg <= {scan_serial_in, ir_sh_reg[`JTDR_IR_W-1:1]}; // see R9
  end

  // Instruction parallel stage on the falling edge
  always_ff @(negedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
      ir_reg <= `JTDR_OP_IDCODE;
    else if (tap_reg == JTDR_TLR)
      ir_reg <= `JTDR_OP_IDCODE; // see R6
    else if (tap_reg == JTDR_UPDIR)
      ir_reg <= ir_sh_reg; // see R9
  end

  // One-stage bypass path
  always_ff @(posedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
      byp_reg <= `JTDR_BYPASS_CAPTURE;
    else if (!sel_bsr && !sel_id && tap_reg == JTDR_CAPDR)
      byp_reg <= `JTDR_BYPASS_CAPTURE; // see R4
    else if (!sel_bsr && !sel_id && tap_reg == JTDR_SHDR)
      byp_reg <= scan_serial_in; // see R4
  end

  // Identification parallel stage holds the fixed word
  always_ff @(negedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
      id_par_reg <= ID_WORD;
    else
      id_par_reg <= ID_WORD; // see R5
  end

  // Identification shift stage
  always_ff @(posedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
      id_sh_reg <= '0;
    else if (sel_id && tap_reg == JTDR_CAPDR)
      id_sh_reg <= id_par_reg; // see R8
    else if (sel_id && tap_reg == JTDR_SHDR)
      id_sh_reg <= {scan_serial_in, id_sh_reg[`JTDR_ID_W-1:1]}; // see R5, R8
  end

  // Pin samples pass two flops before capture
  always_ff @(posedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
    begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
    end
    else
    begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
    end
  end

  // Boundary shift path, cell order fixed by index
  always_ff @(posedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
      bsr_sh_reg <= '0;
    else if (sel_bsr && tap_reg == JTDR_CAPDR)
      bsr_sh_reg <= pin_s2_reg; // see R3, R10
    else if (sel_bsr && tap_reg == JTDR_SHDR)
      bsr_sh_reg <= {scan_serial_in, bsr_sh_reg[`JTDR_BSR_LEN-1:1]}; // see R3
  end

  // Boundary parallel latch and its crossing toggle
  always_ff @(negedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
    begin
      bsr_par_reg <= '0;
      upd_tgl_reg <= 1'b0;
    end
    else if (sel_bsr && tap_reg == JTDR_UPDDR)
    begin
      bsr_par_reg <= bsr_sh_reg; // see R3
      upd_tgl_reg <= ~upd_tgl_reg;
    end
  end

  // Serial output mux, sent on the falling edge
  always_comb
  begin
    if (sel_id)
      sel_out = id_sh_reg[0];
    else if (sel_bsr)
      sel_out = bsr_sh_reg[0];
    else
      sel_out = byp_reg; // see R4
  end

  always_ff @(negedge scan_clock or negedge scan_reset_n)
  begin
    if (!scan_reset_n)
    begin
      scan_serial_out <= 1'b0;
      scan_serial_oe <= 1'b0;
    end
    else
    begin
      scan_serial_out <= (tap_reg == JTDR_SHIR) ? ir_sh_reg[0] : sel_out;
      scan_serial_oe <= (tap_reg == JTDR_SHIR) || (tap_reg == JTDR_SHDR);
    end
  end

  // System side: mode levels and update toggle cross by two flops
  jtdr_mode_s mode_s1_reg;
  jtdr_mode_s mode_reg;
  logic [2:0] tgl_sync_reg;
  jtdr_cells_t bsr_sys_reg;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mode_s1_reg <= '0;
      mode_reg <= '0;
      tgl_sync_reg <= '0;
    end
    else
    begin
      mode_s1_reg <= mode_tck_reg;
      mode_reg <= mode_s1_reg;
      tgl_sync_reg <= {tgl_sync_reg[1:0], upd_tgl_reg};
    end
  end

  // Copy the stable latch once its toggle has arrived
  always_ff @(posedge clk)
  begin
    if (srst)
      bsr_sys_reg <= '0;
    else if (tgl_sync_reg[2] != tgl_sync_reg[1])
      bsr_sys_reg <= bsr_par_reg;
  end

  // Per-pin takeover by extest, clamp and high-impedance
  genvar gi;
  generate
    for (gi = 0; gi < `JTDR_BSR_LEN; gi = gi + 1)
    begin : g_pin
      always_ff @(posedge clk)
      begin
        if (srst)
        begin
          pin_out[gi] <= 1'b0;
          pin_oe[gi] <= 1'b0;
        end
        else if (mode_reg.highz)
        begin
          pin_out[gi] <= core_out[gi];
          pin_oe[gi] <= 1'b0;
        end
        else if (mode_reg.extest || mode_reg.clamp)
        begin
          pin_out[gi] <= bsr_sys_reg[gi];
          pin_oe[gi] <= 1'b1;
        end
        else
        begin
          pin_out[gi] <= core_out[gi];
          pin_oe[gi] <= core_oe[gi];
        end
      end
    end
  endgenerate

  // Checks in the test clock domain
  sequence s_ir_exit;
    (tap_reg == JTDR_EX1IR || tap_reg == JTDR_EX2IR) && scan_mode_select;
  endsequence

  sequence s_id_capture;
    tap_reg == JTDR_CAPDR && sel_id;
  endsequence

  id_capture_a: assert property (@(posedge scan_clock) disable iff (!scan_reset_n) // see R8
    s_id_capture |=> id_sh_reg == ID_WORD)
    else $error("ID word not captured");

  id_layout_a: assert property (@(posedge scan_clock) disable iff (!scan_reset_n) // see R1
    s_id_capture |=> id_sh_reg[`JTDR_ID_FIXED_BIT] == 1'b1
      && id_sh_reg[`JTDR_ID_REV_HI:`JTDR_ID_REV_LO] == ID_REVISION
      && id_sh_reg[`JTDR_ID_DEV_HI:`JTDR_ID_DEV_LO] == ID_DEVICE)
    else $error("ID word fields misplaced");

  id_shift_a: assert property (@(posedge scan_clock) disable iff (!scan_reset_n) // see R5
    s_id_capture ##1 (tap_reg == JTDR_SHDR) |=> scan_serial_out == ID_WORD[1])
    else $error("ID word not shifted out");

  ir_update_a: assert property (@(posedge scan_clock) disable iff (!scan_reset_n) // see R9
    s_ir_exit ##1 (tap_reg == JTDR_UPDIR) |=> ir_reg == $past(ir_sh_reg))
    else $error("Instruction not latched at update");

  tlr_idcode_a: assert property (@(posedge scan_clock) disable iff (!scan_reset_n) // see R6
    (tap_reg == JTDR_TLR) [*2] |-> ir_reg == `JTDR_OP_IDCODE && sel_id)
    else $error("Reset state does not select ID");

  bypass_path_a: assert property (@(posedge scan_clock) disable iff (!scan_reset_n) // see R4
    (tap_reg == JTDR_SHDR && (ir_reg == `JTDR_OP_CLAMP || ir_reg == `JTDR_OP_HIGHZ
      || ir_reg == `JTDR_OP_BYPASS)) |=> byp_reg == $past(scan_serial_in))
    else $error("Bypass stage not in path");

  bsr_shift_a: assert property (@(posedge scan_clock) disable iff (!scan_reset_n) // see R3
    (tap_reg == JTDR_SHDR && sel_bsr) |=>
      bsr_sh_reg == {$past(scan_serial_in), $past(bsr_sh_reg[`JTDR_BSR_LEN-1:1])})
    else $error("Boundary shift wrong");

  bsr_hold_a: assert property (@(posedge scan_clock) disable iff (!scan_reset_n) // see R3, R10
    1'b1 ##1 !(tap_reg == JTDR_UPDDR && sel_bsr) |-> $stable(bsr_par_reg))
    else $error("Boundary latch moved outside update");

endmodule : jtdr_top

/* tb/jtdr_ctrl_model.sv */
`timescale 1ns/1ps
// External test controller; scan clock stands low between frames
module jtdr_ctrl_model
(
  output logic scan_clock,
  output logic scan_reset_n,
  output logic scan_mode_select,
  output logic scan_serial_in,
  input wire logic scan_serial_out
);
  // Idle levels at time zero, test reset asserted
  initial
  begin
    scan_clock = 1'b0;
    scan_reset_n = 1'b0;
    scan_mode_select = 1'b1;
    scan_serial_in = 1'b0;
  end

  // One 48 ns cycle; serial out taken at the rising edge
  task automatic step(input logic m, input logic d, output logic q);
    scan_mode_select = m;
    scan_serial_in = d;
    #24 scan_clock = 1'b1;
    q = scan_serial_out;
    #24 scan_clock = 1'b0;
  endtask : step

  // Non-shift cycle; data line toggles so stale data never looks valid
  task automatic idle(input logic m);
    logic q;
    step(m, ~scan_serial_in, q);
  endtask : idle

  // Test reset, five cycles with mode select high, park in run-test-idle
  task automatic tap_reset();
    scan_reset_n = 1'b0;
    #100 scan_reset_n = 1'b1;
    repeat (5) idle(1'b1);
    idle(1'b0);
  endtask : tap_reset

  // Capture, shift n bits LSB first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic q;
    dout = '0;
    idle(1'b1);
    if (ir)
      idle(1'b1);
    idle(1'b0);
    idle(1'b0);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    idle(1'b1);
    idle(1'b0);
  endtask : scan
endmodule : jtdr_ctrl_model

/* tb/jtdr_top_bench.sv */
`timescale 1ns/1ps
`include "jtdr_regs.svh"
module jtdr_top_bench
  import jtdr_pkg::*;
;
  localparam logic [3:0] ID_REV = 4'h2; // Arbitrary value
  localparam logic [15:0] ID_DEV = 16'h0b7e; // Arbitrary value
  localparam logic [10:0] ID_MFR = 11'h2c5; // Arbitrary value
  logic clk;
  logic srst;
  logic scan_clock;
  logic scan_reset_n;
  logic scan_mode_select;
  logic scan_serial_in;
  logic scan_serial_out;
  logic scan_serial_oe;
  jtdr_cells_t pin_in;
  jtdr_cells_t core_out;
  jtdr_cells_t core_oe;
  jtdr_cells_t pin_out;
  jtdr_cells_t pin_oe;
  logic [31:0] q;
  int err_count = 0;
  int check_count = 0;
  int oe_edges = 0;

  // Count rising edges that see the serial output driven
  always @(posedge scan_clock)
  begin
    if (scan_serial_oe === 1'b1)
      oe_edges++;
  end

  jtdr_top #(.ID_REVISION(ID_REV), .ID_DEVICE(ID_DEV), .ID_MAKER(ID_MFR)) dut_u (
    .clk(clk), .srst(srst), .scan_clock(scan_clock), .scan_reset_n(scan_reset_n),
    .scan_mode_select(scan_mode_select), .scan_serial_in(scan_serial_in),
    .scan_serial_out(scan_serial_out), .scan_serial_oe(scan_serial_oe),
    .pin_in(pin_in), .core_out(core_out), .core_oe(core_oe),
    .pin_out(pin_out), .pin_oe(pin_oe));

  jtdr_ctrl_model ctl_u (.scan_clock(scan_clock), .scan_reset_n(scan_reset_n),
    .scan_mode_select(scan_mode_select), .scan_serial_in(scan_serial_in),
    .scan_serial_out(scan_serial_out));

  // System clock, 100 ns
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Load an instruction; capture pattern comes back out
  task automatic load_ir(input jtdr_ir_t op);
    ctl_u.scan(1'b1, 3, {29'h0, op}, q);
    chk("ir capture", q, 32'h1);
  endtask : load_ir

  // Let pin mode cross to the system clock, then check pins
  task automatic pins(input jtdr_cells_t o, input jtdr_cells_t e);
    repeat (10) @(negedge clk);
    chk("pin_out", {24'h0, pin_out}, {24'h0, o});
    chk("pin_oe", {24'h0, pin_oe}, {24'h0, e});
  endtask : pins

  task automatic t_idcode();
    int e0;
    e0 = oe_edges;
    ctl_u.scan(1'b0, 32, 32'h0, q);
    chk("id after reset", q, {ID_REV, ID_DEV, ID_MFR, 1'h1});
    chk("oe edges", oe_edges - e0, 32'd32);
    pins(core_out, core_oe);
    load_ir(`JTDR_OP_IDCODE);
    ctl_u.scan(1'b0, 32, 32'hffffffff, q);
    chk("id by opcode", q, {ID_REV, ID_DEV, ID_MFR, 1'h1});
    $display("test idcode done");
  endtask : t_idcode

  task automatic t_boundary();
    load_ir(`JTDR_OP_SAMPLE);
    ctl_u.scan(1'b0, 8, 32'h5a, q);
    chk("sample capture", q, 32'h96);
    pins(core_out, core_oe);
    load_ir(`JTDR_OP_EXTEST);
    pins(8'h5a, 8'hff);
    ctl_u.scan(1'b0, 8, 32'ha5, q);
    chk("extest capture", q, 32'h96);
    pins(8'ha5, 8'hff);
    $display("test boundary done");
  endtask : t_boundary

  // One-stage path for bypass, clamp, highz and an unknown code
  task automatic t_bypass();
    jtdr_ir_t ops [4];
    ops = '{`JTDR_OP_BYPASS, `JTDR_OP_CLAMP, `JTDR_OP_HIGHZ, 3'h5};
    foreach (ops[i])
    begin
      load_ir(ops[i]);
      ctl_u.scan(1'b0, 2, 32'h3, q);
      chk("bypass path", q, 32'h2);
      if (ops[i] === `JTDR_OP_CLAMP)
        pins(8'ha5, 8'hff);
      else if (ops[i] === `JTDR_OP_HIGHZ)
        pins(core_out, 8'h00);
      else
        pins(core_out, core_oe);
    end
    $display("test bypass done");
  endtask : t_bypass

  // Mode-select reset alone must bring the ID register back
  task automatic t_tlr();
    repeat (5) ctl_u.idle(1'b1);
    ctl_u.idle(1'b0);
    ctl_u.scan(1'b0, 32, 32'h0, q);
    chk("id after tms reset", q, {ID_REV, ID_DEV, ID_MFR, 1'h1});
    $display("test tlr done");
  endtask : t_tlr

  // Counts and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done

  // Main sequence
  initial
  begin
    srst = 1'b1;
    pin_in = 8'h96;
    core_out = 8'h3c;
    core_oe = 8'hc3;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    ctl_u.tap_reset();
    t_idcode();
    t_boundary();
    t_bypass();
    t_tlr();
    test_done();
  end

  // Watchdog, far beyond the expected run
  initial
  begin
    #2000000;
    err_count++;
    test_done();
  end
endmodule : jtdr_top_bench
